// File: inc/scp_defines.svh
// register offsets, field positions, reset values and counts
`ifndef SCP_DEFINES_SVH
`define SCP_DEFINES_SVH
// ****************************************************************
// register map (byte addresses)
// ****************************************************************
`define SCP_OFF_MODE 4'h0
`define SCP_OFF_WDT 4'h4
`define SCP_OFF_LVD 4'h8
`define SCP_OFF_STAT 4'hc
// ****************************************************************
// field positions
// ****************************************************************
`define SCP_B_FCS 0
`define SCP_B_IDLE 1
`define SCP_B_HTO 2
`define SCP_B_LTO 3
`define SCP_B_FWK 4
`define SCP_DIV_LO 5
`define SCP_DIV_HI 7
`define SCP_B_KEEP 0
`define SCP_B_WDTEN 1
`define SCP_B_LOW_VOLTAGE_DETECT_ENABLE 0
`define SCP_B_FASTW 6
// ****************************************************************
// reset values and counts
// ****************************************************************
`define SCP_MODE_RST 8'h03
`define SCP_WDT_RST 8'h00
`define SCP_LVD_RST 8'h00
`define SCP_DIV_LF_MAX 3'h1
`define SCP_HF_STABLE 11'h400
`define SCP_RESP_OKAY 2'h0
`define SCP_RESP_SLVERR 2'h2
`endif

// File: inc/scp_pkg.sv
// types and helpers shared by the clock and power mode controller
`default_nettype none
`include "scp_defines.svh"
package scp_pkg;
  // operating modes, one-hot
  typedef enum logic [5:0] {
    SCP_NORMAL = 6'h01,
    SCP_SLOW = 6'h02,
    SCP_IDLE_SYS_CLOCK_OFF = 6'h04,
    SCP_IDLE_SYS_CLOCK_ON = 6'h08,
    SCP_DEEP_SLEEP = 6'h10,
    SCP_SLEEP_WITH_SUB_CLOCK = 6'h20
  } scp_mode_t;
  // system clock source, one-hot
  typedef enum logic [2:0] {
    SCP_SRC_HF = 3'h1,
    SCP_SRC_DIV = 3'h2,
    SCP_SRC_LF = 3'h4
  } scp_src_t;
  // clock enables handed to the core and peripherals
  typedef struct packed {
    logic cpu;
    logic system;
    logic substitute;
    logic watchdog;
    logic time_base;
    logic hs_periph;
  } scp_clk_en_t;
  // divider state
  typedef struct packed {
    logic [5:0] cnt;
    logic [2:0] code;
    logic tick;
  } scp_div_state_t;
  // controller state
  typedef struct packed {
    scp_mode_t mode;
    scp_mode_t run_mode;
    scp_src_t src;
    logic [2:0] div_sel;
    logic fwk_en;
    logic idle_en;
    logic fcs;
    logic keep_on;
    logic wdt_en;
    logic lvd_en;
    logic hto;
    logic lto;
    logic fast_wake;
    logic [10:0] hs_cnt;
    logic [1:0] wdt_div;
    scp_clk_en_t clk_en;
    logic hs_osc_on;
    logic lf_osc_on;
    logic wdt_func_en;
    logic aw_got;
    logic [3:0] aw_addr;
    logic w_got;
    logic [7:0] wdata;
    logic wstrb0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } scp_state_t;
  // source chosen by the fast select bit and the divider field
  function automatic scp_src_t scp_pick_src(input logic fcs,
                                           input logic [2:0] div);
    if (fcs) begin
      return SCP_SRC_HF;
    end else if (div <= `SCP_DIV_LF_MAX) begin
      return SCP_SRC_LF;
    end
    return SCP_SRC_DIV;
  endfunction
  // true in the two modes where the cpu executes
  function automatic logic scp_is_run(input scp_mode_t m);
    return (m == SCP_NORMAL) || (m == SCP_SLOW);
  endfunction
endpackage
`default_nettype wire

// File: rtl/scp_clock_ctrl.sv
// system clock selection and operating mode sequencer, axi4-lite slave
`default_nettype none
// Behaviour
// R01: system clock from high or low source
// R02: high source fixed by configuration input
// R03: divided high clock, ratios two to 64
// R04: high oscillator stops when switching to low
// R05: substitute and time base from slow rc
// R06: run from substitute clock right after wake
// R07: watchdog clock: substitute or system/4
// R08: time base clock feeds timers and interrupts
// R09: six modes, two running, four cpu off
// R10: fast mode divides high clock 1..64
// R11: slow mode uses slow rc, high off
// R12: deep sleep stops cpu, sub, watchdog clocks
// R13: voltage detect enabled blocks deep sleep
// R14: sub-clock sleep keeps sub, watchdog when needed
// R15: halt, idle, keep-on low: idle clock off
// R16: idle clock off: watchdog off if system/4
// R17: halt, idle, keep-on high: idle clock on
// R18: idle clock on: watchdog clock keeps running
// R19: idle modes stop cpu, peripherals keep running; in idle clock off the system and hs_periph clocks stop as well
// R20: divider codes: 0,1 low; 2..7 high/64..2
// R21: fast select one gives undivided high clock
// R22: source switching without truncated clock pulses
// R23: wake restores pre-halt mode and clock
module scp_clock_ctrl
  import scp_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  // oscillator ticks and configuration options
  input wire logic hxt_tick,
  input wire logic erc_tick,
  input wire logic internal_fast_rc_osc_tick,
  input wire logic internal_slow_rc_osc_tick,
  input wire logic [1:0] cfg_hs_sel,
  input wire logic cfg_wdt_src_sub,
  // cpu events
  input wire logic halt_req,
  input wire logic wake_req,
  // clock enables and oscillator controls
  output scp_clk_en_t clk_en,
  output logic hs_osc_on,
  output logic lf_osc_on,
  output logic wdt_func_en,
  // axi4-lite slave
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  scp_state_t s_q; // all state
  scp_state_t s_d; // next state
  logic hf_tick; // chosen high speed tick, gated by its enable
  logic lf_tick; // slow rc tick, gated by its enable
  logic div_tick; // divided high speed tick
  logic raw_sys; // tick of the current source
  logic sys_tick; // system clock tick this cycle
  logic sub_tick; // substitute clock tick
  logic sys4_tick; // system clock divided by four
  logic running; // cpu executes
  logic sys_live; // system clock runs in this mode
  scp_src_t want_src; // source the register asks for
  logic [31:0] rd_word; // read mux
  logic rd_ok; // read address mapped
  // reset words as sized constants, since a literal cannot be sliced
  localparam logic [7:0] MODE_RST = `SCP_MODE_RST;
  localparam logic [7:0] WDT_RST = `SCP_WDT_RST;
  localparam logic [7:0] LVD_RST = `SCP_LVD_RST;
  // ****************************************************************
  // tick sources
  // ****************************************************************
  // the high oscillator is a configuration choice, not a register
  always_comb begin
    unique case (cfg_hs_sel)
      2'h0: hf_tick = hxt_tick & s_q.hs_osc_on; // see R02
      2'h1: hf_tick = erc_tick & s_q.hs_osc_on; // see R02
      default: hf_tick = internal_fast_rc_osc_tick & s_q.hs_osc_on; // see R02
    endcase
  end
  assign lf_tick = internal_slow_rc_osc_tick & s_q.lf_osc_on;
  scp_hs_divider u_div (
    .clk(clk),
    .sys_rst(sys_rst),
    .tick_in(hf_tick),
    .ratio_code(s_q.div_sel),
    .tick_out(div_tick)
  );
  // pick the tick that drives the system clock
  always_comb begin
    unique case (s_q.src)
      SCP_SRC_HF: raw_sys = hf_tick; // see R21
      SCP_SRC_DIV: raw_sys = div_tick; // see R10
      default: raw_sys = lf_tick; // see R01
    endcase
  end
  assign running = scp_is_run(s_q.mode);
  assign sys_live = running || (s_q.mode == SCP_IDLE_SYS_CLOCK_ON); // see R17
  // a high source gives no ticks until its oscillator is stable
  assign sys_tick = raw_sys && sys_live &&
                    (s_q.src == SCP_SRC_LF || s_q.hto);
  assign sub_tick = lf_tick && (s_q.mode != SCP_DEEP_SLEEP); // see R05
  assign sys4_tick = sys_tick && (s_q.wdt_div == 2'h3); // see R07
  assign want_src = scp_pick_src(s_q.fcs, s_q.div_sel); // see R20
  // ****************************************************************
  // read multiplexer
  // ****************************************************************
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok = 1'b1;
    unique case (s_axi_araddr)
      `SCP_OFF_MODE: begin
        rd_word[`SCP_DIV_HI:`SCP_DIV_LO] = s_q.div_sel;
        rd_word[`SCP_B_FWK] = s_q.fwk_en;
        rd_word[`SCP_B_LTO] = s_q.lto;
        rd_word[`SCP_B_HTO] = s_q.hto;
        rd_word[`SCP_B_IDLE] = s_q.idle_en;
        rd_word[`SCP_B_FCS] = s_q.fcs;
      end
      `SCP_OFF_WDT: begin
        rd_word[`SCP_B_KEEP] = s_q.keep_on;
        rd_word[`SCP_B_WDTEN] = s_q.wdt_en;
      end
      `SCP_OFF_LVD: begin
        rd_word[`SCP_B_LOW_VOLTAGE_DETECT_ENABLE] = s_q.lvd_en;
      end
      `SCP_OFF_STAT: begin
        rd_word[5:0] = s_q.mode;
        rd_word[`SCP_B_FASTW] = s_q.fast_wake;
      end
      default: begin
        rd_ok = 1'b0;
      end
    endcase
  end
  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    s_d = s_q;
    // --- axi write channels, taken in either order
    if (s_axi_awvalid && s_q.awready) begin
      s_d.aw_got = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_q.wready) begin
      s_d.w_got = 1'b1;
      s_d.wdata = s_axi_wdata[7:0];
      s_d.wstrb0 = s_axi_wstrb[0];
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = `SCP_RESP_OKAY;
      unique case (s_q.aw_addr)
        `SCP_OFF_MODE: begin
          if (s_q.wstrb0) begin
            s_d.div_sel = s_q.wdata[`SCP_DIV_HI:`SCP_DIV_LO];
            s_d.fwk_en = s_q.wdata[`SCP_B_FWK];
            s_d.idle_en = s_q.wdata[`SCP_B_IDLE];
            s_d.fcs = s_q.wdata[`SCP_B_FCS];
          end
        end
        `SCP_OFF_WDT: begin
          if (s_q.wstrb0) begin
            s_d.keep_on = s_q.wdata[`SCP_B_KEEP];
            s_d.wdt_en = s_q.wdata[`SCP_B_WDTEN];
          end
        end
        `SCP_OFF_LVD: begin
          if (s_q.wstrb0) begin
            s_d.lvd_en = s_q.wdata[`SCP_B_LOW_VOLTAGE_DETECT_ENABLE];
          end
        end
        `SCP_OFF_STAT: begin
          s_d.bresp = `SCP_RESP_OKAY; // status is read only
        end
        default: begin
          s_d.bresp = `SCP_RESP_SLVERR;
        end
      endcase
    end
    s_d.awready = !s_d.aw_got && !s_d.bvalid;
    s_d.wready = !s_d.w_got && !s_d.bvalid;
    // --- axi read channel
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_q.arready) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = rd_word;
      s_d.rresp = rd_ok ? `SCP_RESP_OKAY : `SCP_RESP_SLVERR;
    end
    s_d.arready = !s_d.rvalid;
    // --- mode sequencing
    if (running) begin
      // the running mode follows the clock selection
      s_d.mode = (want_src == SCP_SRC_LF) ? SCP_SLOW : SCP_NORMAL; // see R11
      if (halt_req) begin
        s_d.run_mode = s_d.mode; // see R23
        if (s_q.idle_en) begin
          s_d.mode = s_q.keep_on ? SCP_IDLE_SYS_CLOCK_ON : SCP_IDLE_SYS_CLOCK_OFF; // see R15 R17
        end else if (s_q.lvd_en || (s_q.wdt_en && cfg_wdt_src_sub)) begin
          // deep sleep is refused while voltage detect is on
          s_d.mode = SCP_SLEEP_WITH_SUB_CLOCK; // see R13 R14
        end else begin
          s_d.mode = SCP_DEEP_SLEEP; // see R12
        end
      end
    end else if (wake_req) begin
      s_d.mode = s_q.run_mode; // see R23
      // fast wake needs a live substitute clock to lean on
      if (s_q.run_mode == SCP_NORMAL && s_q.fwk_en && !s_q.hto &&
          (s_q.mode == SCP_SLEEP_WITH_SUB_CLOCK || s_q.mode == SCP_IDLE_SYS_CLOCK_OFF)) begin
        s_d.fast_wake = 1'b1; // see R06
      end
    end
    // --- glitch-free source switch: only at an old-source tick, or
    // while the high oscillator is stopped or not yet stable
    if (s_q.src != want_src &&
        (raw_sys || !(s_q.hs_osc_on && s_q.hto))) begin
      s_d.src = want_src; // see R22
    end
    // --- oscillator enables
    s_d.hs_osc_on = (s_d.mode == SCP_NORMAL) ||
                    (s_d.mode == SCP_IDLE_SYS_CLOCK_ON &&
                     s_d.run_mode == SCP_NORMAL); // see R04
    s_d.lf_osc_on = (s_d.mode != SCP_DEEP_SLEEP); // see R12
    // --- oscillator ready flags
    if (!s_q.hs_osc_on) begin
      s_d.hto = 1'b0;
      s_d.hs_cnt = 11'h000;
    end else if (hf_tick && !s_q.hto) begin
      s_d.hs_cnt = s_q.hs_cnt + 11'h001;
      s_d.hto = (s_d.hs_cnt == `SCP_HF_STABLE);
    end
    if (s_d.hto || !scp_is_run(s_d.mode)) begin
      s_d.fast_wake = 1'b0; // hand back to the high source
    end
    if (!s_q.lf_osc_on) begin
      s_d.lto = 1'b0;
    end else if (lf_tick) begin
      s_d.lto = 1'b1;
    end
    // --- watchdog prescaler on the system clock
    if (sys_tick) begin
      s_d.wdt_div = s_q.wdt_div + 2'h1;
    end
    // --- clock enables for the next cycle
    s_d.clk_en.system = sys_tick; // see R01
    s_d.clk_en.cpu = running &&
                     (s_q.fast_wake ? sub_tick : sys_tick); // see R06 R19
    s_d.clk_en.substitute = sub_tick; // see R05
    s_d.clk_en.watchdog = cfg_wdt_src_sub ?
                          sub_tick : sys4_tick; // see R07 R16 R18
    s_d.clk_en.time_base = lf_tick && (s_q.mode != SCP_DEEP_SLEEP) &&
                           (s_q.mode != SCP_SLEEP_WITH_SUB_CLOCK); // see R08
    s_d.clk_en.hs_periph = hf_tick && s_q.hto; // see R04
    s_d.wdt_func_en = s_q.wdt_en && (s_q.mode != SCP_DEEP_SLEEP); // see R12
  end
  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_q <= '0;
      s_q.mode <= SCP_NORMAL;
      s_q.run_mode <= SCP_NORMAL;
      s_q.src <= SCP_SRC_HF;
      s_q.div_sel <= MODE_RST[`SCP_DIV_HI:`SCP_DIV_LO];
      s_q.fwk_en <= MODE_RST[`SCP_B_FWK];
      s_q.idle_en <= MODE_RST[`SCP_B_IDLE];
      s_q.fcs <= MODE_RST[`SCP_B_FCS];
      s_q.keep_on <= WDT_RST[`SCP_B_KEEP];
      s_q.wdt_en <= WDT_RST[`SCP_B_WDTEN];
      s_q.lvd_en <= LVD_RST[`SCP_B_LOW_VOLTAGE_DETECT_ENABLE];
      s_q.hs_osc_on <= 1'b1;
      s_q.lf_osc_on <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end
  // outputs straight from the state register
  assign clk_en = s_q.clk_en;
  assign hs_osc_on = s_q.hs_osc_on;
  assign lf_osc_on = s_q.lf_osc_on;
  assign wdt_func_en = s_q.wdt_func_en;
  assign s_axi_awready = s_q.awready;
  assign s_axi_wready = s_q.wready;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign s_axi_rvalid = s_q.rvalid;
  // ****************************************************************
  // assertions
  // ****************************************************************
  a_deep_sleep_quiet: assert property (@(posedge clk) disable iff (sys_rst)
    (s_q.mode == SCP_DEEP_SLEEP && $past(s_q.mode) == SCP_DEEP_SLEEP) |->
    !clk_en.cpu && !clk_en.substitute && !clk_en.watchdog &&
    !clk_en.time_base && !wdt_func_en)
    else $error("clock running in deep sleep"); // see R12
  a_lvd_blocks: assert property (@(posedge clk) disable iff (sys_rst)
    (halt_req && running && !s_q.idle_en && s_q.lvd_en) |=>
    s_q.mode == SCP_SLEEP_WITH_SUB_CLOCK)
    else $error("deep sleep entered with voltage detect on"); // see R13
  a_idle_keep: assert property (@(posedge clk) disable iff (sys_rst)
    (halt_req && running && s_q.idle_en) |=>
    s_q.mode == ($past(s_q.keep_on) ? SCP_IDLE_SYS_CLOCK_ON : SCP_IDLE_SYS_CLOCK_OFF))
    else $error("wrong idle mode on halt"); // see R15 R17
  a_slow_hs_off: assert property (@(posedge clk) disable iff (sys_rst)
    (s_q.mode == SCP_SLOW && $past(s_q.mode) == SCP_SLOW) |->
    !hs_osc_on && !clk_en.hs_periph)
    else $error("high oscillator on in slow mode"); // see R11 R04
  a_cpu_halted: assert property (@(posedge clk) disable iff (sys_rst)
    (!running && !scp_is_run($past(s_q.mode))) |-> !clk_en.cpu)
    else $error("cpu clocked in a halted mode"); // see R09 R19
  a_idle_sys_clock_off_wdt: assert property (@(posedge clk) disable iff (sys_rst)
    (s_q.mode == SCP_IDLE_SYS_CLOCK_OFF && $past(s_q.mode) == SCP_IDLE_SYS_CLOCK_OFF &&
     !cfg_wdt_src_sub) |-> !clk_en.watchdog)
    else $error("watchdog clock on in idle with system source"); // see R16
  a_wake_restore: assert property (@(posedge clk) disable iff (sys_rst)
    (wake_req && !running) |=> s_q.mode == $past(s_q.run_mode))
    else $error("wake did not restore running mode"); // see R23
  a_tbc_source: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en.time_base |-> $past(internal_slow_rc_osc_tick) && $past(s_q.lf_osc_on))
    else $error("time base tick without slow rc tick"); // see R05 R08
  a_sub_wdt: assert property (@(posedge clk) disable iff (sys_rst)
    (cfg_wdt_src_sub && s_q.mode == SCP_IDLE_SYS_CLOCK_ON &&
     $past(s_q.mode) == SCP_IDLE_SYS_CLOCK_ON && $past(internal_slow_rc_osc_tick)) |-> clk_en.watchdog)
    else $error("watchdog clock lost in idle with clock on"); // see R18
endmodule
`default_nettype wire

// File: rtl/scp_hs_divider.sv
// high speed tick divider, ratio 2 to 64, switching only on a wrap
`default_nettype none
module scp_hs_divider
  import scp_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic tick_in,
  input wire logic [2:0] ratio_code,
  output logic tick_out
);
  scp_div_state_t s_q;
  scp_div_state_t s_d;
  // terminal count for a code: 2 gives 63, 7 gives 1
  function automatic logic [5:0] div_limit(input logic [2:0] code);
    return 6'((7'h40 >> (code - 3'h2)) - 7'h01);
  endfunction
  // ****************************************************************
  // count, latching a new ratio only when the count is at zero
  // ****************************************************************
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (s_q.cnt == 6'h00) begin
      // a ratio change mid-period would cut the pulse short
      s_d.code = (ratio_code < 3'h2) ? 3'h7 : ratio_code; // see R22
    end
    if (tick_in) begin
      if (s_q.cnt >= div_limit(s_d.code)) begin
        s_d.cnt = 6'h00;
        s_d.tick = 1'b1; // see R03
      end else begin
        s_d.cnt = s_q.cnt + 6'h01;
      end
    end
  end
  // state register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_q <= '{cnt: 6'h00, code: 3'h7, tick: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end
  assign tick_out = s_q.tick;
  // one output pulse per full period of the latched ratio
  a_div_period: assert property (@(posedge clk) disable iff (sys_rst)
    s_q.tick |-> $past(tick_in) && $past(s_q.cnt) >= div_limit($past(s_q.code)))
    else $error("divider pulse before terminal count"); // see R03
endmodule
`default_nettype wire

// File: test/scp_far_model.sv
// oscillator ticks and clock consumer counters facing the controller
`default_nettype none
module scp_far_model
  import scp_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic hs_osc_on,
  input wire logic lf_osc_on,
  input wire scp_clk_en_t clk_en,
  input wire logic clr,
  output logic hxt_tick,
  output logic erc_tick,
  output logic internal_fast_rc_osc_tick,
  output logic internal_slow_rc_osc_tick,
  output logic [5:0][31:0] seen
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************************************
  // oscillators
  // ****************************************************************
  logic [7:0] ph_q; // phase, 192 is a multiple of every tick period
  always_ff @(posedge clk) begin
    ph_q <= (sys_rst || ph_q == 8'hbf) ? 8'h00 : ph_q + 8'h01;
  end
  // a stopped oscillator gives no tick at all, not a stale one
  assign hxt_tick = hs_osc_on && ph_q[0] == 1'b0;
  assign erc_tick = hs_osc_on && ph_q % 8'h03 == 8'h00;
  assign internal_fast_rc_osc_tick = hs_osc_on && ph_q[1:0] == 2'h0;
  assign internal_slow_rc_osc_tick = lf_osc_on && ph_q[3:0] == 4'h0;
  // ****************************************************************
  // consumers
  // ****************************************************************
  // each consumer counts the enable pulses it receives
  always_ff @(posedge clk) begin
    for (int i = 0; i < 6; i++) begin
      seen[i] <= clr ? 32'h0 : seen[i] + 32'(clk_en[i]);
    end
  end
endmodule
`default_nettype wire

// File: test/tb_top.sv
// self-checking bench for the clock and power mode controller
`default_nettype none
`include "scp_defines.svh"
module tb_top
  import scp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [1:0] cfg_hs_sel = 2'h0;
  logic wsub = 1'b0; // watchdog from substitute clock
  logic halt_req = 1'b0, wake_req = 1'b0, clr = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid, hs_on, lf_on, wfe;
  logic external_crystal_osc, external_rc_osc, internal_fast_rc_osc, internal_slow_rc_osc;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, rd_q, sysn;
  logic [5:0][31:0] seen;
  logic [17:0] v;
  logic [6:0] got;
  scp_clk_en_t clk_en;
  int err_count = 0, n_tests = 0, n;
  // mode reads 0x03 plus lto: the slow rc ticks on the first edge
  logic [31:0] rst_v [4] = '{32'h0b, 32'h00, 32'h00, 32'h01};
  int hs_per [3] = '{2, 3, 4}; // tick period of each high source
  // idle keep wdt_en lvd wsub | mode | cpu sys sub wdt tb lf wfe
  logic [17:0] hc [8] = '{{5'b00000, 6'h10, 7'b0000000},
    {5'b00100, 6'h10, 7'b0000000}, {5'b00011, 6'h20, 7'b0011010},
    {5'b00101, 6'h20, 7'b0011011}, {5'b10000, 6'h04, 7'b0010110},
    {5'b10001, 6'h04, 7'b0011110}, {5'b11000, 6'h08, 7'b0111110},
    {5'b11001, 6'h08, 7'b0111110}};
  always #4 clk = ~clk;
  scp_far_model far (.clk(clk), .sys_rst(sys_rst), .hs_osc_on(hs_on),
    .lf_osc_on(lf_on), .clk_en(clk_en), .clr(clr), .hxt_tick(external_crystal_osc),
    .erc_tick(external_rc_osc), .internal_fast_rc_osc_tick(internal_fast_rc_osc), .internal_slow_rc_osc_tick(internal_slow_rc_osc), .seen(seen));
  scp_clock_ctrl dut (.clk(clk), .sys_rst(sys_rst), .hxt_tick(external_crystal_osc),
    .erc_tick(external_rc_osc), .internal_fast_rc_osc_tick(internal_fast_rc_osc), .internal_slow_rc_osc_tick(internal_slow_rc_osc),
    .cfg_hs_sel(cfg_hs_sel), .cfg_wdt_src_sub(wsub),
    .halt_req(halt_req), .wake_req(wake_req), .clk_en(clk_en),
    .hs_osc_on(hs_on), .lf_osc_on(lf_on), .wdt_func_en(wfe),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // an exhausted wait is a mismatch and ends the run
  task automatic tmo(input int k);
    if (k >= 100) begin
      err_count++;
      $display("CHECK FAILED wait expected answer seen none");
      results();
    end
  endtask
  // bready stays high from the start, so the answer edge ends it
  task automatic wr(input logic [3:0] a, input logic [7:0] d,
                    input logic [3:0] s, input logic [1:0] er);
    int k;
    k = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      k++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && k < 100);
    bready <= 1'b0;
    tmo(k);
    chk("bresp", 32'(er), 32'(bresp));
  endtask
  task automatic rd(input logic [3:0] a, input logic [1:0] er);
    int k;
    k = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      k++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && k < 100);
    rready <= 1'b0;
    rd_q = rdata;
    tmo(k);
    chk("rresp", 32'(er), 32'(rresp));
  endtask
  // counts enable pulses over exactly len cycles
  task automatic count(input int len);
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (len + 1) @(posedge clk);
  endtask
  task automatic pulse(input logic h);
    @(posedge clk);
    if (h) halt_req <= 1'b1;
    else wake_req <= 1'b1;
    @(posedge clk);
    halt_req <= 1'b0;
    wake_req <= 1'b0;
  endtask
  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    // each high source in turn, with a fresh reset for each
    for (int s = 2; s >= 0; s--) begin
      cfg_hs_sel <= 2'(s);
      sys_rst <= 1'b1;
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      for (int a = 0; a < 4; a++) begin
        rd(4'(a * 4), `SCP_RESP_OKAY);
        chk("reset value", rst_v[a], rd_q);
      end
      n = 0;
      do begin
        repeat (50) @(posedge clk);
        rd(`SCP_OFF_MODE, `SCP_RESP_OKAY);
        n++;
      end while (rd_q[2] !== 1'b1 && n < 100);
      tmo(n);
      chk("mode reg", 32'h0f, rd_q);
      count(96);
      chk("cpu ticks", 32'(96 / hs_per[s]), seen[5]);
      $display("test source %0d done", s);
    end
    // unmapped, read-only and masked-lane accesses
    wr(4'h2, 8'hff, 4'hf, `SCP_RESP_SLVERR);
    rd(4'h2, `SCP_RESP_SLVERR);
    chk("unmapped", 32'h0, rd_q);
    wr(`SCP_OFF_STAT, 8'hff, 4'hf, `SCP_RESP_OKAY);
    rd(`SCP_OFF_STAT, `SCP_RESP_OKAY);
    chk("status", 32'h01, rd_q);
    wr(`SCP_OFF_WDT, 8'h03, 4'he, `SCP_RESP_OKAY);
    rd(`SCP_OFF_WDT, `SCP_RESP_OKAY);
    chk("lane", 32'h0, rd_q);
    $display("test registers done");
    // every divider code, ending on the slow clock
    for (int c = 7; c >= 0; c--) begin
      wr(`SCP_OFF_MODE, {3'(c), 5'h00}, 4'h1, `SCP_RESP_OKAY);
      repeat (300) @(posedge clk);
      count(256);
      sysn = c < 2 ? 32'd16 : 32'd64 >> (7 - c);
      chk("system ticks", sysn, seen[4]);
      chk("cpu ticks", sysn, seen[5]);
      chk("sub ticks", 32'd16, seen[3]);
      chk("base ticks", 32'd16, seen[1]);
      if (sysn[1:0] == 2'h0) chk("wdt ticks", sysn >> 2, seen[2]);
      chk("high osc", 32'(c >= 2), 32'(hs_on));
      chk("hs ticks", c < 2 ? 32'd0 : 32'd128, seen[0]);
      rd(`SCP_OFF_STAT, `SCP_RESP_OKAY);
      chk("mode", c < 2 ? 32'h02 : 32'h01, rd_q);
      rd(`SCP_OFF_MODE, `SCP_RESP_OKAY);
      chk("mode reg", {c, 5'h0} | (c < 2 ? 8'h08 : 8'h0c), rd_q);
    end
    $display("test divider done");
    // halt from the slow mode, a stray halt and a stray wake ignored
    for (int k = 0; k < 8; k++) begin
      v = hc[k];
      wsub <= v[13];
      wr(`SCP_OFF_WDT, {6'h00, v[15], v[16]}, 4'h1, `SCP_RESP_OKAY);
      wr(`SCP_OFF_LVD, {7'h00, v[14]}, 4'h1, `SCP_RESP_OKAY);
      wr(`SCP_OFF_MODE, {6'h00, v[17], 1'b0}, 4'h1, `SCP_RESP_OKAY);
      pulse(1'b1);
      pulse(1'b1);
      repeat (4) @(posedge clk);
      rd(`SCP_OFF_STAT, `SCP_RESP_OKAY);
      chk("mode", 32'(v[12:7]), rd_q);
      count(128);
      got = {seen[5] != 0, seen[4] != 0, seen[3] != 0, seen[2] != 0,
        seen[1] != 0, lf_on, wfe};
      chk("clocks", 32'(v[6:0]), 32'(got));
      pulse(1'b0);
      pulse(1'b0);
      repeat (4) @(posedge clk);
      rd(`SCP_OFF_STAT, `SCP_RESP_OKAY);
      chk("mode", 32'h02, rd_q);
      $display("test halt case %0d done", k);
    end
    results();
  end
endmodule
`default_nettype wire
